/* logic/seq_servo_pkg.sv */
package seq_servo_pkg;
  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_NS       = 1000;
  localparam int TICK_CYC      = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PRE_W         = 8;
  localparam logic [PRE_W-1:0] TICK_LAST = PRE_W'(TICK_CYC - 1);

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int TIMER_W = 16;
  localparam int READ_W  = 16;
  localparam int DAC_W   = 10;
  localparam int RATIO_W = 8;

  // ----------------------------------------------------------------
  // encodings and values
  // ----------------------------------------------------------------
  localparam logic [1:0] ONCFG_VIN  = 2'h0;
  localparam logic [1:0] ONCFG_OP   = 2'h1;
  localparam logic [1:0] ONCFG_CTRL = 2'h2;
  localparam logic [1:0] ONCFG_BOTH = 2'h3;

  localparam logic [1:0] DACM_SOFT  = 2'h0;
  localparam logic [1:0] DACM_DISC  = 2'h1;
  localparam logic [1:0] DACM_MSOFT = 2'h2;
  localparam logic [1:0] DACM_MHARD = 2'h3;

  localparam logic [1:0] MARGIN_NOM  = 2'h0;
  localparam logic [1:0] MARGIN_HIGH = 2'h1;
  localparam logic [1:0] MARGIN_LOW  = 2'h2;

  localparam logic [DAC_W-1:0]  DAC_RESET = 10'h200;
  localparam logic [DAC_W-1:0]  SOFT_TOL  = 10'h001;
  localparam logic [READ_W-1:0] FAST_NEAR = 16'h0010;
  localparam logic [READ_W-1:0] SLOW_BAND = 16'h0002;

  typedef enum logic [2:0] {
    ST_OFF  = 3'b000,
    ST_TON  = 3'b001,
    ST_RISE = 3'b010,
    ST_ON   = 3'b011,
    ST_TOFF = 3'b100
  } ch_state_t;

  typedef struct packed {
    ch_state_t          state;
    logic [TIMER_W-1:0] timer;
    logic               en;
    logic               rise_done;
    logic [1:0]         margin;
    logic               force_conn;
    logic [DAC_W-1:0]   dac;
    logic               conn;
    logic               fast;
    logic               settled;
    logic               fault_latched;
    logic               prop;
    logic               st_ov;
    logic               st_warn;
    logic               st_tonmax;
    logic               st_dis;
  } ch_t;
endpackage

/* logic/channel_sequence_servo_margin.sv */
`timescale 1ns/10ps
module channel_sequence_servo_margin
  import seq_servo_pkg::*;
#(
  parameter int NUM_CH = 8
) (
  input  wire logic                             clk_in,
  input  wire logic                             rst_n_in,
  input  wire logic                             on_off_control_in,
  input  wire logic                             vin_above_on_in,
  input  wire logic                             vin_below_off_in,
  input  wire logic                             clear_faults_in,
  input  wire logic [NUM_CH-1:0]                op_on_in,
  input  wire logic [NUM_CH-1:0][1:0]           op_margin_in,
  input  wire logic [NUM_CH-1:0]                op_write_in,
  input  wire logic                             op_global_in,
  input  wire logic [NUM_CH-1:0][1:0]           on_cfg_in,
  input  wire logic [NUM_CH-1:0][1:0]           dac_mode_in,
  input  wire logic [NUM_CH-1:0]                cont_trim_in,
  input  wire logic [NUM_CH-1:0]                servo_on_warn_in,
  input  wire logic [NUM_CH-1:0]                fast_servo_disable_in,
  input  wire logic [NUM_CH-1:0]                ov_ignore_margin_in,
  input  wire logic [NUM_CH-1:0]                tonmax_disable_in,
  input  wire logic [NUM_CH-1:0]                tonmax_propagate_in,
  input  wire logic [NUM_CH-1:0][TIMER_W-1:0]   ton_delay_in,
  input  wire logic [NUM_CH-1:0][TIMER_W-1:0]   ton_rise_in,
  input  wire logic [NUM_CH-1:0][TIMER_W-1:0]   ton_max_in,
  input  wire logic [NUM_CH-1:0][TIMER_W-1:0]   toff_delay_in,
  input  wire logic [NUM_CH-1:0][READ_W-1:0]    vout_command_in,
  input  wire logic [NUM_CH-1:0][READ_W-1:0]    margin_high_in,
  input  wire logic [NUM_CH-1:0][READ_W-1:0]    margin_low_in,
  input  wire logic [NUM_CH-1:0][READ_W-1:0]    ov_fault_limit_in,
  input  wire logic [NUM_CH-1:0][READ_W-1:0]    uv_fault_limit_in,
  input  wire logic [NUM_CH-1:0][READ_W-1:0]    ov_warn_limit_in,
  input  wire logic [NUM_CH-1:0][READ_W-1:0]    uv_warn_limit_in,
  input  wire logic [NUM_CH-1:0][RATIO_W-1:0]   discharge_threshold_ratio_in,
  input  wire logic [NUM_CH-1:0][READ_W-1:0]    vout_reading_in,
  input  wire logic [NUM_CH-1:0]                vout_valid_in,
  input  wire logic [NUM_CH-1:0][DAC_W-1:0]     feedback_code_in,
  input  wire logic [NUM_CH-1:0][DAC_W-1:0]     dac_code_in,
  input  wire logic [NUM_CH-1:0]                dac_write_in,
  output logic      [NUM_CH-1:0]                converter_enable_out,
  output logic      [NUM_CH-1:0][DAC_W-1:0]     trim_dac_output_out,
  output logic      [NUM_CH-1:0]                trim_dac_oe_n_out,
  output logic      [NUM_CH-1:0]                ov_fault_out,
  output logic      [NUM_CH-1:0]                warn_out,
  output logic      [NUM_CH-1:0]                tonmax_fault_out,
  output logic      [NUM_CH-1:0]                discharge_wait_out,
  output logic                                  shared_fault_line_out,
  output logic                                  shared_fault_line_oe_n_out,
  output logic                                  alert_output_low_out,
  output logic                                  alert_output_low_oe_n_out
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [READ_W-1:0] adiff(input logic [READ_W-1:0] a, input logic [READ_W-1:0] b);
    adiff = (a > b) ? (a - b) : (b - a);
  endfunction

  function automatic logic [READ_W-1:0] dext(input logic [DAC_W-1:0] v);
    dext = {{(READ_W-DAC_W){1'b0}}, v};
  endfunction

  // saturating one-code step
  function automatic logic [DAC_W-1:0] step(input logic [DAC_W-1:0] v, input logic up);
    step = v;
    if (up && (v != {DAC_W{1'b1}})) begin
      step = v + DAC_W'(1);
    end else if (!up && (v != '0)) begin
      step = v - DAC_W'(1);
    end
  endfunction

  function automatic logic [READ_W-1:0] disch(input logic [RATIO_W-1:0] r, input logic [READ_W-1:0] c);
    logic [READ_W+RATIO_W-1:0] p;
    p = r * c;
    disch = p[READ_W+RATIO_W-1:RATIO_W];
  endfunction

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic [1:0] rst_sync_q;
  logic       rst_q;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_q = rst_sync_q[1];

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0]             ctrl_sync;
    logic                   vin_ok;
    logic [PRE_W-1:0]       pre;
    ch_t [NUM_CH-1:0]       ch;
  } state_t;

  state_t              q;
  state_t              d;
  logic                tick;
  logic [NUM_CH-1:0]   on_req;

  always_comb begin
    ch_t              c;
    logic             ctrl;
    logic             qual;
    logic             want;
    logic [READ_W-1:0] rd;
    logic [READ_W-1:0] tgt;
    logic [READ_W-1:0] err;
    c    = '0;
    ctrl = 1'b0;
    qual = 1'b0;
    want = 1'b0;
    rd   = '0;
    tgt  = '0;
    err  = '0;
    on_req = '0;
    d = q;
    d.ctrl_sync = {q.ctrl_sync[0], on_off_control_in};
    ctrl = q.ctrl_sync[1];
    tick = (q.pre == TICK_LAST);
    d.pre = tick ? '0 : q.pre + PRE_W'(1);
    if (vin_above_on_in) begin
      d.vin_ok = 1'b1;
    end
    if (vin_below_off_in) begin
      d.vin_ok = 1'b0;
    end
    for (int i = 0; i < NUM_CH; i++) begin
      c  = q.ch[i];
      rd = vout_reading_in[i];
      case (on_cfg_in[i])
        ONCFG_VIN:  qual = 1'b1;
        ONCFG_OP:   qual = op_on_in[i];
        ONCFG_CTRL: qual = ctrl;
        default:    qual = op_on_in[i] & ctrl;
      endcase
      on_req[i] = q.vin_ok & qual;
      if (!on_req[i]) begin
        c.fault_latched = 1'b0;
        c.prop = 1'b0;
      end
      // clear first so a same-cycle event still sets
      if (clear_faults_in) begin
        c.st_ov     = 1'b0;
        c.st_warn   = 1'b0;
        c.st_tonmax = 1'b0;
        c.st_dis    = 1'b0;
      end
      if (op_write_in[i] && (q.ch[i].state == ST_ON) && (op_margin_in[i] != q.ch[i].margin)) begin
        c.margin  = op_margin_in[i];
        c.settled = 1'b0;
        c.fast    = q.ch[i].conn & ~fast_servo_disable_in[i];
        // per-page margin forces connection; global does not
        if ((op_margin_in[i] != MARGIN_NOM) && !op_global_in) begin
          c.force_conn = 1'b1;
        end
      end
      if (c.margin == MARGIN_NOM) begin
        c.force_conn = 1'b0;
      end
      case (q.ch[i].state)
        ST_OFF: begin
          c.rise_done = 1'b0;
          c.margin    = MARGIN_NOM;
          if (on_req[i] && !q.ch[i].fault_latched) begin
            // hold off until the output has discharged
            if (rd > disch(discharge_threshold_ratio_in[i], vout_command_in[i])) begin
              c.st_dis = 1'b1;
            end else begin
              c.state = ST_TON;
              c.timer = '0;
            end
          end
        end
        ST_TON: begin
          if (!on_req[i]) begin
            c.state = ST_OFF;
          end else if (q.ch[i].timer >= ton_delay_in[i]) begin
            c.en    = 1'b1;
            c.state = ST_RISE;
            c.timer = '0;
          end
        end
        ST_RISE: begin
          if (!on_req[i]) begin
            c.state = ST_TOFF;
            c.timer = '0;
          end else begin
            if (q.ch[i].timer >= ton_rise_in[i]) begin
              c.rise_done = 1'b1;
            end
            // undervoltage check at max rise time
            if (q.ch[i].timer >= ton_max_in[i]) begin
              c.rise_done = 1'b1;
              c.state     = ST_ON;
              if (rd < uv_fault_limit_in[i]) begin
                c.st_tonmax = 1'b1;
                if (tonmax_disable_in[i]) begin
                  c.en            = 1'b0;
                  c.state         = ST_OFF;
                  c.fault_latched = 1'b1;
                  c.prop          = tonmax_propagate_in[i];
                end
              end
            end
          end
        end
        ST_ON: begin
          if (!on_req[i]) begin
            c.state = ST_TOFF;
            c.timer = '0;
          end
        end
        default: begin
          // off delay measured from start of off sequence
          if (q.ch[i].timer >= toff_delay_in[i]) begin
            c.en    = 1'b0;
            c.state = ST_OFF;
          end
        end
      endcase
      if (tick && (c.timer != {TIMER_W{1'b1}})) begin
        c.timer = c.timer + TIMER_W'(1);
      end
      if (vin_below_off_in) begin
        c.state     = ST_OFF;
        c.en        = 1'b0;
        c.rise_done = 1'b0;
        c.margin    = MARGIN_NOM;
      end
      // ----------------------------------------------------------------
      // dac connection and servo
      // ----------------------------------------------------------------
      tgt = (q.ch[i].margin == MARGIN_HIGH) ? margin_high_in[i] :
            (q.ch[i].margin == MARGIN_LOW)  ? margin_low_in[i]  : vout_command_in[i];
      // old margin keeps the dac connected one cycle past a return to nominal
      want = c.rise_done & ((dac_mode_in[i] != DACM_DISC) | c.force_conn |
             (q.ch[i].conn & (q.ch[i].margin != MARGIN_NOM)));
      if (!want) begin
        c.conn = 1'b0;
        c.fast = 1'b0;
      end else if (!q.ch[i].conn) begin
        if (dac_mode_in[i] == DACM_MHARD) begin
          c.dac  = dac_code_in[i];
          c.conn = 1'b1;
        end else if (adiff(dext(q.ch[i].dac), dext(feedback_code_in[i])) <= dext(SOFT_TOL)) begin
          // close only near the feedback node
          c.conn    = 1'b1;
          c.settled = 1'b0;
          c.fast    = (dac_mode_in[i] == DACM_SOFT) | c.force_conn ? ~fast_servo_disable_in[i] : 1'b0;
        end else begin
          // approach the feedback code before connecting
          c.dac = step(q.ch[i].dac, q.ch[i].dac < feedback_code_in[i]);
        end
      end else if (dac_mode_in[i][1] && !q.ch[i].force_conn) begin
        // manual modes move only on register write unless a margin forces connection
        if (dac_write_in[i]) begin
          c.dac = dac_code_in[i];
        end
      end else begin
        err = adiff(rd, tgt);
        if (vout_valid_in[i]) begin
          // reservo when leaving the warning window
          if (servo_on_warn_in[i] && !cont_trim_in[i] &&
              ((rd > ov_warn_limit_in[i]) || (rd < uv_warn_limit_in[i]))) begin
            c.settled = 1'b0;
          end
          if (err <= FAST_NEAR) begin
            c.fast = 1'b0;
          end
          // one update per reading until settled, or on every reading with continuous trim
          if (cont_trim_in[i] || !c.settled) begin
            if (err <= SLOW_BAND) begin
              c.settled = 1'b1;
            end else if (!c.fast) begin
              c.dac = step(q.ch[i].dac, rd < tgt);
            end
          end
        end
        // fast ramp one code per tick
        if (c.fast && tick) begin
          c.dac = step(q.ch[i].dac, rd < tgt);
        end
      end
      if (vout_valid_in[i]) begin
        // overvoltage unless margining with ignore set
        if ((rd > ov_fault_limit_in[i]) && !((q.ch[i].margin != MARGIN_NOM) && ov_ignore_margin_in[i])) begin
          c.st_ov = 1'b1;
        end
        if ((rd > ov_warn_limit_in[i]) || (rd < uv_warn_limit_in[i])) begin
          c.st_warn = 1'b1;
        end
      end
      d.ch[i] = c;
    end
  end

  always_ff @(posedge clk_in or negedge rst_q) begin
    if (!rst_q) begin
      q <= '0;
      for (int i = 0; i < NUM_CH; i++) begin
        q.ch[i].dac <= DAC_RESET;
      end
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  always_comb begin
    shared_fault_line_oe_n_out = 1'b1;
    alert_output_low_oe_n_out  = 1'b1;
    for (int i = 0; i < NUM_CH; i++) begin
      converter_enable_out[i] = q.ch[i].en;
      trim_dac_output_out[i]  = q.ch[i].dac;
      trim_dac_oe_n_out[i]    = ~q.ch[i].conn;
      ov_fault_out[i]         = q.ch[i].st_ov;
      warn_out[i]             = q.ch[i].st_warn;
      tonmax_fault_out[i]     = q.ch[i].st_tonmax;
      discharge_wait_out[i]   = q.ch[i].st_dis;
      if (q.ch[i].prop) begin
        shared_fault_line_oe_n_out = 1'b0;
      end
      if (q.ch[i].st_ov || q.ch[i].st_warn || q.ch[i].st_tonmax || q.ch[i].st_dis) begin
        alert_output_low_oe_n_out = 1'b0;
      end
    end
  end
  assign shared_fault_line_out = 1'b0;
  assign alert_output_low_out  = 1'b0;

  // ----------------------------------------------------------------
  // checks on channel 0, and on every enable after input voltage loss
  // ----------------------------------------------------------------
  property p_vin_off;
    @(posedge clk_in) disable iff (!rst_q) vin_below_off_in |=> (converter_enable_out == '0);
  endproperty
  a_vin_off: assert property (p_vin_off) else $error("enable stayed high after input voltage loss");

  property p_vin_gate;
    @(posedge clk_in) disable iff (!rst_q)
      (q.ch[0].state == ST_OFF) && !q.vin_ok |=> (q.ch[0].state == ST_OFF);
  endproperty
  a_vin_gate: assert property (p_vin_gate) else $error("channel left off without input voltage");

  property p_ton;
    @(posedge clk_in) disable iff (!rst_q)
      $rose(converter_enable_out[0]) |-> ($past(q.ch[0].timer) >= $past(ton_delay_in[0])) &&
                                          ($past(q.ch[0].state) == ST_TON);
  endproperty
  a_ton: assert property (p_ton) else $error("enable rose before on delay");

  property p_toff;
    @(posedge clk_in) disable iff (!rst_q)
      $fell(converter_enable_out[0]) && ($past(q.ch[0].state) == ST_TOFF) && !$past(vin_below_off_in)
      |-> ($past(q.ch[0].timer) >= $past(toff_delay_in[0]));
  endproperty
  a_toff: assert property (p_toff) else $error("enable fell before off delay");

  property p_disc;
    @(posedge clk_in) disable iff (!rst_q)
      (dac_mode_in[0] == DACM_DISC) && (q.ch[0].margin == MARGIN_NOM) && !q.ch[0].force_conn
      ##1 (dac_mode_in[0] == DACM_DISC) |-> trim_dac_oe_n_out[0];
  endproperty
  a_disc: assert property (p_disc) else $error("trim output driven in disconnected mode");

  property p_margin_keep;
    @(posedge clk_in) disable iff (!rst_q)
      q.ch[0].conn && (q.ch[0].margin != MARGIN_NOM) && (q.ch[0].state == ST_ON) &&
      on_req[0] && !vin_below_off_in |=> q.ch[0].conn;
  endproperty
  a_margin_keep: assert property (p_margin_keep) else $error("dac disconnected while margining");

  property p_hold_off;
    @(posedge clk_in) disable iff (!rst_q)
      (q.ch[0].state == ST_OFF) && on_req[0] && !q.ch[0].fault_latched && !vin_below_off_in &&
      (vout_reading_in[0] > disch(discharge_threshold_ratio_in[0], vout_command_in[0]))
      |=> (q.ch[0].state == ST_OFF) && q.ch[0].st_dis && !alert_output_low_oe_n_out;
  endproperty
  a_hold_off: assert property (p_hold_off) else $error("channel not held off above threshold");

  property p_clear;
    @(posedge clk_in) disable iff (!rst_q)
      clear_faults_in && !vout_valid_in[0] && (q.ch[0].state == ST_ON) |=> !ov_fault_out[0] && !tonmax_fault_out[0];
  endproperty
  a_clear: assert property (p_clear) else $error("status survived clear faults");

  property p_soft;
    @(posedge clk_in) disable iff (!rst_q)
      $rose(q.ch[0].conn) && ($past(dac_mode_in[0]) != DACM_MHARD)
      |-> (adiff(dext($past(q.ch[0].dac)), dext($past(feedback_code_in[0]))) <= dext(SOFT_TOL));
  endproperty
  a_soft: assert property (p_soft) else $error("soft connect closed away from feedback code");

endmodule

/* sim/dcdc_model.sv */
`timescale 1ns/10ps
module dcdc_model
  import seq_servo_pkg::*;
(
  input  wire logic                   clk_in,
  input  wire logic                   rst_n_in,
  input  wire logic [7:0]             en_in,
  input  wire logic [7:0][DAC_W-1:0]  dac_in,
  input  wire logic [7:0]             dac_oe_n_in,
  output logic      [7:0][READ_W-1:0] vout_out,
  output logic      [7:0]             valid_out,
  output logic      [7:0][DAC_W-1:0]  fb_out
);
  logic [4:0] cnt_q;
  // ------------------------------------------------------------
  // converters: one reading every 20 cycles, dead outputs bleed
  // ------------------------------------------------------------
  // the slow bleed lets a restart find the output still high
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_q <= '0;
      valid_out <= '0;
      vout_out <= '0;
      fb_out <= '0;
    end else begin
      cnt_q <= (cnt_q == 5'h13) ? 5'h00 : cnt_q + 5'h01;
      valid_out <= {8{cnt_q == 5'h13}};
      for (int i = 0; i < 8; i++) begin
        fb_out[i] <= 10'h180;
        if (cnt_q == 5'h13)
          vout_out[i] <= en_in[i] ? 16'h0800 + (dac_oe_n_in[i] ? 16'h0200 : 16'(dac_in[i]))
                       : (vout_out[i] > 16'h0010 ? vout_out[i] - 16'h0010 : 16'h0000);
      end
    end
  end
endmodule

/* sim/channel_sequence_servo_margin_tb_top.sv */
`timescale 1ns/10ps
module channel_sequence_servo_margin_tb_top
  import seq_servo_pkg::*;
;
  logic                    clk, rst_n, ctrl, vin_on, vin_off, clr, glob, sfl, sfl_oe_n, alert, alert_oe_n;
  logic [7:0]              op_on, op_wr, cont, srv_warn, fast_dis, ov_ign, tm_dis, tm_prop, valid, dac_wr;
  logic [7:0]              en, oe_n, ovf, wrn, tmf, dwait;
  logic [7:0][1:0]         op_m, on_cfg, dmode;
  logic [7:0][TIMER_W-1:0] ton_d, ton_r, ton_m, toff_d;
  logic [7:0][READ_W-1:0]  cmd, mhi, mlo, ovfl, uvfl, ovwl, uvwl, rd;
  logic [7:0][RATIO_W-1:0] ratio;
  logic [7:0][DAC_W-1:0]   fb, dcode, tdac;
  int                      num_errors, checks;

  channel_sequence_servo_margin i_channel_sequence_servo_margin (
    .clk_in(clk), .rst_n_in(rst_n), .on_off_control_in(ctrl), .vin_above_on_in(vin_on),
    .vin_below_off_in(vin_off), .clear_faults_in(clr), .op_on_in(op_on), .op_margin_in(op_m),
    .op_write_in(op_wr), .op_global_in(glob), .on_cfg_in(on_cfg), .dac_mode_in(dmode),
    .cont_trim_in(cont), .servo_on_warn_in(srv_warn), .fast_servo_disable_in(fast_dis),
    .ov_ignore_margin_in(ov_ign), .tonmax_disable_in(tm_dis), .tonmax_propagate_in(tm_prop),
    .ton_delay_in(ton_d), .ton_rise_in(ton_r), .ton_max_in(ton_m), .toff_delay_in(toff_d),
    .vout_command_in(cmd), .margin_high_in(mhi), .margin_low_in(mlo), .ov_fault_limit_in(ovfl),
    .uv_fault_limit_in(uvfl), .ov_warn_limit_in(ovwl), .uv_warn_limit_in(uvwl),
    .discharge_threshold_ratio_in(ratio), .vout_reading_in(rd), .vout_valid_in(valid),
    .feedback_code_in(fb), .dac_code_in(dcode), .dac_write_in(dac_wr), .converter_enable_out(en),
    .trim_dac_output_out(tdac), .trim_dac_oe_n_out(oe_n), .ov_fault_out(ovf), .warn_out(wrn),
    .tonmax_fault_out(tmf), .discharge_wait_out(dwait), .shared_fault_line_out(sfl),
    .shared_fault_line_oe_n_out(sfl_oe_n), .alert_output_low_out(alert),
    .alert_output_low_oe_n_out(alert_oe_n));

  dcdc_model i_dcdc_model (.clk_in(clk), .rst_n_in(rst_n), .en_in(en), .dac_in(tdac),
    .dac_oe_n_in(oe_n), .vout_out(rd), .valid_out(valid), .fb_out(fb));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic check(input string what, input logic [16:0] seen, input logic [16:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic margin_write(input logic [1:0] m);
    op_m[0] = m;
    op_wr[0] = 1'b1;
    cyc(1);
    op_wr[0] = 1'b0;
  endtask

  task automatic report_and_stop;
    if (num_errors == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  initial begin
    {rst_n, ctrl, vin_on, vin_off, clr, glob, op_wr, dac_wr, op_m, srv_warn, fast_dis, ov_ign} = '0;
    num_errors = 0;
    checks = 0;
    op_on = 8'h0B;
    cont = '1;
    tm_dis = 8'h02;
    tm_prop = 8'h02;
    on_cfg = {ONCFG_OP, ONCFG_OP, ONCFG_OP, ONCFG_OP, ONCFG_BOTH, ONCFG_CTRL, ONCFG_OP, ONCFG_VIN};
    dmode = {{5{DACM_SOFT}}, DACM_MHARD, DACM_SOFT, DACM_SOFT};
    ton_d = {8{16'h0002}};
    ton_d[1] = 16'h0004;
    ton_r = {8{16'h0006}};
    ton_m = {8{16'h0008}};
    toff_d = {8{16'h0002}};
    toff_d[3] = 16'h0005;
    cmd = {8{16'h0A00}};
    mhi = {8{16'h0A20}};
    mlo = {8{16'h09E0}};
    ovfl = {8{16'hFFFF}};
    uvfl = {8{16'h0400}};
    uvfl[1] = 16'h0F00;
    ovwl = {8{16'hFFF0}};
    uvwl = '0;
    ratio = {8{8'h80}};
    dcode = {8{10'h123}};
    repeat (10) @(posedge clk);
    #1 rst_n = 1'b1;
    cyc(400);
    check("enable without vin", en, 17'h0);
    vin_on = 1'b1;
    cyc(280);
    check("early enables", en, 17'h01);
    check("connect before rise", oe_n, 17'hFF);
    ctrl = 1'b1;
    cyc(1300);
    check("ton max fault", {tmf[1], en[1], sfl_oe_n, alert_oe_n}, 17'h8);
    check("qualified enables", en, 17'h0D);
    check("hard connect", {oe_n[2], tdac[2]}, 17'h123);
    dcode[2] = 10'h155;
    dac_wr[2] = 1'b1;
    cyc(1);
    dac_wr[2] = 1'b0;
    cyc(3);
    check("written code", tdac[2], 17'h155);
    cyc(15000);
    check("servo nominal", {oe_n[0], tdac[0] >= 10'h1FE && tdac[0] <= 10'h202}, 17'h1);
    margin_write(MARGIN_HIGH);
    cyc(6000);
    check("margin high", tdac[0] >= 10'h21E && tdac[0] <= 10'h222, 17'h1);
    dmode[0] = DACM_DISC;
    cyc(20);
    check("disconnect while margined", oe_n[0], 17'h0);
    margin_write(MARGIN_NOM);
    cyc(20);
    check("disconnect from on", oe_n[0], 17'h1);
    // host duty: a global margin never connects a disconnected dac
    glob = 1'b1;
    margin_write(MARGIN_HIGH);
    glob = 1'b0;
    cyc(20);
    check("global margin stays disconnected", oe_n[0], 17'h1);
    margin_write(MARGIN_LOW);
    cyc(600);
    check("forced connect", oe_n[0], 17'h0);
    ctrl = 1'b0;
    cyc(280);
    check("off delays", en[3:2], 17'h2);
    ctrl = 1'b1;
    cyc(100);
    check("held off", {en[2], dwait[2], alert_oe_n}, 17'h2);
    cyc(2000);
    check("on after discharge", en[2], 17'h1);
    clr = 1'b1;
    cyc(1);
    clr = 1'b0;
    cyc(2);
    check("cleared", {tmf, dwait, alert_oe_n}, 17'h1);
    vin_off = 1'b1;
    cyc(3);
    check("vin loss", en, 17'h0);
    ovfl[0] = 16'h0100;
    ovwl[0] = 16'h0100;
    cyc(25);
    check("ov and warn status", {ovf[0], wrn[0], alert_oe_n, alert, sfl}, 17'h18);
    report_and_stop;
  end

  initial begin
    repeat (40000) @(posedge clk);
    num_errors++;
    report_and_stop;
  end
endmodule
